//--- logic/crf_framer.sv
// Conversion readout framer: holds results, builds the readout byte frame
// and shifts it out MSB first on the serial clock.
// Assumes a command decoder on the system clock and a host that keeps the
// chip select high until o_busy falls before starting a frame.
//
// Contract
// - Primary frame is four, five or six bytes per status and check enables.
// - Primary order: status, four data bytes MSB first, check byte last.
// - Auxiliary frame uses three data bytes followed by a zero pad byte.
// - Without status byte, all later bytes move forward one place.
// - Status byte sent only while config bit 2 at address 02h is set.
// - Status bit 7 flags auxiliary data new since last auxiliary read.
// - Status bit 6 flags primary data new since last primary read.
// - Status bit 5 reports external converter clock in use.
// - Status bit 4 shows the low reference alarm.
// - Status bit 3 shows the amplifier absolute low alarm.
// - Status bit 2 shows the amplifier absolute high alarm.
// - Status bit 1 shows the amplifier differential range alarm.
// - Status bit 0 mirrors the power register reset flag.
// - Primary result is 32-bit two's complement, bit 31 sent first.
// - Zero input maps to the all-zero code.
// - Primary result saturates at the positive and negative full-scale codes.
// - Auxiliary result is 24-bit two's complement, saturating likewise.
// - Check mode 01 sends low byte of data byte sum plus 9Bh.
// - Check mode 10 sends CRC-8 remainder with polynomial 100000111.
// - Continued serial clock repeats the frame from its first byte.
// - Register reads carry no check byte.
module crf_framer import crf_pkg::*; #(
    parameter int PRI_RAW_W = 34,
    parameter int AUX_RAW_W = 26
) (
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Converter results
    input wire logic i_pri_valid,
    input wire logic [PRI_RAW_W-1:0] i_pri_raw,
    input wire logic i_aux_valid,
    input wire logic [AUX_RAW_W-1:0] i_aux_raw,
    // Monitors and clock source
    input wire logic i_ext_clk,
    input wire logic i_ref_low,
    input wire logic i_amp_low,
    input wire logic i_amp_high,
    input wire logic i_amp_diff,
    input wire logic i_reset_flag,
    // Register write port
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    // Read commands
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_sel,
    input wire logic [7:0] i_cmd_reg_byte,
    // Serial link
    input wire logic i_sclk,
    input wire logic i_cs_b,
    // Outputs
    output logic o_dout,
    output logic o_busy,
    output logic [7:0] o_cfg,
    output logic [7:0] o_status
);
    // System domain state
    crf_state_t state_q, state_d;
    crf_sel_t sel_q, sel_d;
    logic [7:0] cfg_q, cfg_d;
    logic [31:0] pri_word_q, pri_word_d;
    logic [23:0] aux_word_q, aux_word_d;
    logic pri_new_q, pri_new_d;
    logic aux_new_q, aux_new_d;
    logic [31:0] word_q, word_d;
    logic [7:0] snap_q, snap_d;
    logic [7:0] reg_byte_q, reg_byte_d;
    logic [FRAME_BITS-1:0] fr_q, fr_d;
    logic [2:0] len_q, len_d;
    logic busy_q, busy_d;
    logic [7:0] status_q, status_d;
    logic cs_m_q, cs_s_q;
    // Combinational helpers
    logic take;
    logic pri_ovf;
    logic aux_ovf;
    logic st_en;
    logic ck_en;
    logic [31:0] data;
    logic [7:0] check;
    // Link domain state
    logic link_rst_b;
    logic [5:0] cnt_q, cnt_d;
    logic [5:0] bit_last;
    logic [5:0] bit_idx;
    logic dout_q, dout_d;

    crf_check u_check (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_word(word_q),
        .i_mode(cfg_q[CFG_CHK_MSB:CFG_CHK_LSB]),
        .o_check(check)
    );

    assign pri_ovf = !(&i_pri_raw[PRI_RAW_W-1:31]) && (|i_pri_raw[PRI_RAW_W-1:31]);
    assign aux_ovf = !(&i_aux_raw[AUX_RAW_W-1:23]) && (|i_aux_raw[AUX_RAW_W-1:23]);
    assign take = (state_q == ST_IDLE) && i_cmd_valid && cs_s_q && (i_cmd_sel != 2'h3);

    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        cfg_d = cfg_q;
        pri_word_d = pri_word_q;
        aux_word_d = aux_word_q;
        word_d = word_q;
        snap_d = snap_q;
        reg_byte_d = reg_byte_q;
        fr_d = fr_q;
        len_d = len_q;
        st_en = cfg_q[CFG_ST_EN_BIT] && (sel_q != SEL_REG);
        ck_en = ((cfg_q[CFG_CHK_MSB:CFG_CHK_LSB] == CHK_SUM) || (cfg_q[CFG_CHK_MSB:CFG_CHK_LSB] == CHK_CRC))
            && (sel_q != SEL_REG);
        data = (sel_q == SEL_AUX) ? {word_q[23:0], PAD_BYTE} : word_q;
        if (i_reg_wr && i_reg_addr == CFG_ADDR) begin
            cfg_d = i_reg_wdata;
        end
        // Results pass unchanged unless beyond full scale
        if (i_pri_valid) begin
            if (pri_ovf) begin
                pri_word_d = i_pri_raw[PRI_RAW_W-1] ? PRI_NEG_FS : PRI_POS_FS;
            end else begin
                pri_word_d = i_pri_raw[31:0];
            end
        end
        if (i_aux_valid) begin
            if (aux_ovf) begin
                aux_word_d = i_aux_raw[AUX_RAW_W-1] ? AUX_NEG_FS : AUX_POS_FS;
            end else begin
                aux_word_d = i_aux_raw[23:0];
            end
        end
        // Live status byte
        status_d = 8'h00;
        status_d[ST_AUX_NEW] = aux_new_q;
        status_d[ST_PRI_NEW] = pri_new_q;
        status_d[ST_EXT_CLK] = i_ext_clk;
        status_d[ST_REF_LOW] = i_ref_low;
        status_d[ST_AMP_LOW] = i_amp_low;
        status_d[ST_AMP_HIGH] = i_amp_high;
        status_d[ST_AMP_DIFF] = i_amp_diff;
        status_d[ST_RESET] = i_reset_flag;
        // Set wins over the read that clears
        pri_new_d = i_pri_valid || (pri_new_q && !(take && i_cmd_sel == SEL_PRI));
        aux_new_d = i_aux_valid || (aux_new_q && !(take && i_cmd_sel == SEL_AUX));
        unique case (state_q)
            ST_IDLE: begin
                if (take) begin
                    sel_d = crf_sel_t'(i_cmd_sel);
                    snap_d = status_d;
                    reg_byte_d = i_cmd_reg_byte;
                    // Auxiliary word zero-extended so check covers three bytes
                    word_d = (i_cmd_sel == SEL_AUX) ? {8'h00, aux_word_q} : pri_word_q;
                    state_d = ST_CALC;
                end
            end
            ST_CALC: begin
                state_d = ST_BUILD;
            end
            ST_BUILD: begin
                if (sel_q == SEL_REG) begin
                    fr_d = {reg_byte_q, 40'h0};
                    len_d = REG_BYTES;
                end else if (st_en) begin
                    fr_d = {snap_q, data, ck_en ? check : 8'h00};
                    len_d = DATA_BYTES + 3'h1 + 3'(ck_en);
                end else begin
                    fr_d = {data, ck_en ? check : 8'h00, 8'h00};
                    len_d = DATA_BYTES + 3'(ck_en);
                end
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        busy_d = (state_d != ST_IDLE) || !cs_s_q;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            sel_q <= SEL_PRI;
            cfg_q <= CFG_RST;
            pri_word_q <= 32'h0;
            aux_word_q <= 24'h0;
            pri_new_q <= 1'b0;
            aux_new_q <= 1'b0;
            word_q <= 32'h0;
            snap_q <= 8'h00;
            reg_byte_q <= 8'h00;
            fr_q <= '0;
            len_q <= REG_BYTES;
            busy_q <= 1'b1;
            status_q <= 8'h00;
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            cfg_q <= cfg_d;
            pri_word_q <= pri_word_d;
            aux_word_q <= aux_word_d;
            pri_new_q <= pri_new_d;
            aux_new_q <= aux_new_d;
            word_q <= word_d;
            snap_q <= snap_d;
            reg_byte_q <= reg_byte_d;
            fr_q <= fr_d;
            len_q <= len_d;
            busy_q <= busy_d;
            status_q <= status_d;
            cs_m_q <= i_cs_b;
            cs_s_q <= cs_m_q;
        end
    end

    // Link side: frame words are quasi-static while chip select is low
    assign link_rst_b = i_rst_b && !i_cs_b;
    assign bit_last = {len_q, 3'h0} - 6'h01;
    assign bit_idx = 6'(FRAME_BITS - 1) - cnt_q;

    always_comb begin
        cnt_d = (cnt_q == bit_last) ? 6'h00 : cnt_q + 6'h01;
        dout_d = fr_q[bit_idx];
    end

    always_ff @(posedge i_sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            cnt_q <= 6'h00;
            dout_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            dout_q <= dout_d;
        end
    end

    assign o_dout = dout_q;
    assign o_busy = busy_q;
    assign o_cfg = cfg_q;
    assign o_status = status_q;

    pri_flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_pri_valid |=> pri_new_q)
        else $error("primary new flag not set");

    aux_flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_aux_valid |=> aux_new_q)
        else $error("auxiliary new flag not set");

    pri_flag_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (take && i_cmd_sel == SEL_PRI && !i_pri_valid) |=> !pri_new_q)
        else $error("primary new flag not cleared by read");

    frame_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_q == ST_BUILD && sel_q != SEL_REG)
        |=> (len_q == DATA_BYTES + 3'($past(st_en)) + 3'($past(ck_en))))
        else $error("frame length wrong");

    status_lead_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_q == ST_BUILD && sel_q != SEL_REG && cfg_q[CFG_ST_EN_BIT])
        |=> (fr_q[47:40] == $past(snap_q)))
        else $error("status byte not leading");

    no_status_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_q == ST_BUILD && sel_q == SEL_PRI && !cfg_q[CFG_ST_EN_BIT])
        |=> (fr_q[47:16] == $past(word_q)))
        else $error("data not moved forward");

    aux_pad_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_q == ST_BUILD && sel_q == SEL_AUX && cfg_q[CFG_ST_EN_BIT])
        |=> (fr_q[15:8] == PAD_BYTE && fr_q[39:16] == $past(word_q[23:0])))
        else $error("auxiliary pad byte wrong");

    reg_no_check_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (take && i_cmd_sel == SEL_REG) |-> ##3 (len_q == REG_BYTES))
        else $error("register read frame not one byte");

    sat_pos_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_pri_valid && pri_ovf && !i_pri_raw[PRI_RAW_W-1]) |=> (pri_word_q == PRI_POS_FS))
        else $error("primary result not saturated");

    frame_wrap_a: assert property (@(posedge i_sclk) disable iff (!link_rst_b)
        (cnt_q == bit_last) |=> (cnt_q == 6'h00))
        else $error("frame does not restart");

    msb_first_a: assert property (@(posedge i_sclk) disable iff (!link_rst_b)
        (cnt_q == 6'h00) |=> (o_dout == fr_q[FRAME_BITS-1]))
        else $error("first bit is not frame MSB");
endmodule

//--- logic/crf_pkg.sv
// Constants and types shared by the conversion readout framer.
// Assumes nothing beyond a SystemVerilog compiler.
package crf_pkg;
    // Serial port configuration register
    localparam logic [7:0] CFG_ADDR = 8'h02;
    localparam logic [7:0] CFG_RST = 8'h04;
    localparam int CFG_ST_EN_BIT = 2;
    localparam int CFG_CHK_MSB = 1;
    localparam int CFG_CHK_LSB = 0;
    // Check byte modes and constants
    localparam logic [1:0] CHK_SUM = 2'h1;
    localparam logic [1:0] CHK_CRC = 2'h2;
    localparam logic [7:0] CHK_OFFSET = 8'h9b;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] PAD_BYTE = 8'h00;
    // Frame geometry
    localparam logic [2:0] DATA_BYTES = 3'h4;
    localparam logic [2:0] REG_BYTES = 3'h1;
    localparam int FRAME_BITS = 48;
    // Code limits
    localparam logic [31:0] PRI_POS_FS = 32'h7fffffff;
    localparam logic [31:0] PRI_NEG_FS = 32'h80000000;
    localparam logic [23:0] AUX_POS_FS = 24'h7fffff;
    localparam logic [23:0] AUX_NEG_FS = 24'h800000;
    // Status byte bit positions
    localparam int ST_AUX_NEW = 7;
    localparam int ST_PRI_NEW = 6;
    localparam int ST_EXT_CLK = 5;
    localparam int ST_REF_LOW = 4;
    localparam int ST_AMP_LOW = 3;
    localparam int ST_AMP_HIGH = 2;
    localparam int ST_AMP_DIFF = 1;
    localparam int ST_RESET = 0;
    // Read selection and build sequence
    typedef enum logic [1:0] {
        SEL_PRI = 2'b00,
        SEL_AUX = 2'b01,
        SEL_REG = 2'b10
    } crf_sel_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALC = 2'b01,
        ST_BUILD = 2'b10
    } crf_state_t;
endpackage

//--- logic/crf_check.sv
// Check byte generator: sum-plus-offset or CRC-8 over a 32-bit word.
// Assumes shorter words are zero-extended at the top; leading zero bytes
// change neither result.
module crf_check import crf_pkg::*; (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Word and mode
    input wire logic [31:0] i_word,
    input wire logic [1:0] i_mode,
    // Check byte, one cycle after the word
    output logic [7:0] o_check
);
    logic [7:0] check_d;
    logic [7:0] check_q;

    always_comb begin
        logic [7:0] sum;
        logic [7:0] crc;
        sum = 8'h00;
        crc = 8'h00;
        check_d = 8'h00;
        sum = i_word[31:24] + i_word[23:16] + i_word[15:8] + i_word[7:0] + CHK_OFFSET;
        // Bitwise long division, message shifted by eight zero bits
        for (int i = 31; i >= 0; i--) begin
            if (crc[7] ^ i_word[i]) begin
                crc = {crc[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                crc = {crc[6:0], 1'b0};
            end
        end
        if (i_mode == CHK_SUM) begin
            check_d = sum;
        end else if (i_mode == CHK_CRC) begin
            check_d = crc;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            check_q <= 8'h00;
        end else begin
            check_q <= check_d;
        end
    end

    assign o_check = check_q;

    sum_example_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_word == 32'h12345678 && i_mode == CHK_SUM) |=> (o_check == 8'haf))
        else $error("checksum of example word wrong");

    crc_example_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_word == 32'h00000001 && i_mode == CHK_CRC) |=> (o_check == 8'h07))
        else $error("crc of single low bit wrong");
endmodule

//--- verif/crf_host_model.sv
// Host side of the readout link: selects the framer and clocks a frame out.
// Assumes the caller starts a read only while the framer reports idle.
module crf_host_model (
    // Serial data from the framer
    input wire logic i_dout,
    // Serial clock and chip select
    output logic o_sclk,
    output logic o_cs_b
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
    end

    // Clock runs only inside a frame, 6 ns period, sampled on the falling edge
    task automatic read_bits(input int n, output logic [127:0] bits);
        bits = '0;
        #1.3;
        o_cs_b = 1'b0;
        #4;
        repeat (n) begin
            o_sclk = 1'b1;
            #3;
            o_sclk = 1'b0;
            bits = {bits[126:0], i_dout};
            #3;
        end
        #4;
        o_cs_b = 1'b1;
    endtask
endmodule

//--- verif/crf_framer_tb.sv
// Self-checking bench for the conversion readout framer.
// Assumes the host model in crf_host_model and the package crf_pkg.
module crf_framer_tb import crf_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0, rst_b = 1'b0, pri_valid = 1'b0, aux_valid = 1'b0;
    logic ext_clk = 1'b0, ref_low = 1'b0, amp_low = 1'b0, amp_high = 1'b0, amp_diff = 1'b0, reset_flag = 1'b0;
    logic reg_wr = 1'b0, cmd_valid = 1'b0;
    logic [33:0] pri_raw = '0;
    logic [25:0] aux_raw = '0;
    logic [7:0] reg_addr = '0, reg_wdata = '0, cmd_reg_byte = '0, cur_cfg = CFG_RST;
    logic [1:0] cmd_sel = '0;
    wire logic sclk, cs_b, dout, busy;
    wire logic [7:0] cfg, status;
    int error_cnt = 0;
    int compares = 0;

    always #12.5 clk_sys = ~clk_sys;

    crf_framer #(.PRI_RAW_W(34), .AUX_RAW_W(26)) dut (.i_clk_sys(clk_sys), .i_rst_b(rst_b),
        .i_pri_valid(pri_valid), .i_pri_raw(pri_raw), .i_aux_valid(aux_valid), .i_aux_raw(aux_raw),
        .i_ext_clk(ext_clk), .i_ref_low(ref_low), .i_amp_low(amp_low), .i_amp_high(amp_high),
        .i_amp_diff(amp_diff), .i_reset_flag(reset_flag), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_cmd_valid(cmd_valid), .i_cmd_sel(cmd_sel), .i_cmd_reg_byte(cmd_reg_byte),
        .i_sclk(sclk), .i_cs_b(cs_b), .o_dout(dout), .o_busy(busy), .o_cfg(cfg), .o_status(status));

    crf_host_model host (.i_dout(dout), .o_sclk(sclk), .o_cs_b(cs_b));

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] sum8(input logic [31:0] w, input int nb);
        logic [7:0] s;
        s = CHK_OFFSET;
        for (int i = 0; i < nb; i++)
            s = s + w[8*i +: 8];
        return s;
    endfunction

    function automatic logic [7:0] crc8(input logic [31:0] w, input int nb);
        logic [7:0] c;
        c = 8'h00;
        for (int i = nb - 1; i >= 0; i--) begin
            c = c ^ w[8*i +: 8];
            for (int k = 0; k < 8; k++)
                c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Live status byte from the bench's own monitor levels
    function automatic logic [7:0] st(input logic aux_new, input logic pri_new);
        return {aux_new, pri_new, ext_clk, ref_low, amp_low, amp_high, amp_diff, reset_flag};
    endfunction

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 50) begin
            error_cnt++;
            $display("mismatch at %0t: busy never fell", $time);
            end_sim;
        end
    endtask

    task automatic wr_cfg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        if (a == CFG_ADDR)
            cur_cfg = d;
        check(cfg, cur_cfg);
    endtask

    task automatic store(input logic aux, input logic [33:0] raw);
        @(negedge clk_sys);
        if (aux) begin
            aux_raw = raw[25:0];
            aux_valid = 1'b1;
        end else begin
            pri_raw = raw;
            pri_valid = 1'b1;
        end
        @(negedge clk_sys);
        pri_valid = 1'b0;
        aux_valid = 1'b0;
        @(negedge clk_sys);
    endtask

    // Issue a read, clock reps frames out and compare with the expected frame
    task automatic chk_frame(input logic [1:0] sel, input logic [31:0] w, input logic [7:0] s, input int reps);
        logic [127:0] f, exp, got;
        int n, nb;
        f = '0;
        n = 0;
        nb = (sel == SEL_PRI) ? 4 : 3;
        if (sel == SEL_REG) begin
            f = w[7:0];
            n = 8;
        end else begin
            if (cur_cfg[CFG_ST_EN_BIT]) begin
                f = s;
                n = 8;
            end
            f = (f << 32) | ((sel == SEL_PRI) ? w : {w[23:0], PAD_BYTE});
            n = n + 32;
            if (cur_cfg[1:0] == CHK_SUM || cur_cfg[1:0] == CHK_CRC) begin
                f = (f << 8) | ((cur_cfg[1:0] == CHK_SUM) ? sum8(w, nb) : crc8(w, nb));
                n = n + 8;
            end
        end
        exp = '0;
        repeat (reps) exp = (exp << n) | f;
        @(negedge clk_sys);
        cmd_sel = sel;
        cmd_reg_byte = w[7:0];
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        repeat (2) @(negedge clk_sys);
        wait_idle;
        host.read_bits(n * reps, got);
        wait_idle;
        check(got, exp);
    endtask

    task automatic t_status;
        {ext_clk, ref_low, amp_low, amp_high, amp_diff, reset_flag} = 6'b110101;
        store(1'b0, 34'h012345678);
        store(1'b1, 34'h3ffffff);
        check(status, st(1'b1, 1'b1));
        chk_frame(SEL_PRI, 32'h12345678, st(1'b1, 1'b1), 1);
        check(status, st(1'b1, 1'b0));
        {ext_clk, ref_low, amp_low, amp_high, amp_diff, reset_flag} = 6'b001010;
        chk_frame(SEL_PRI, 32'h12345678, st(1'b1, 1'b0), 2);
        {ext_clk, ref_low, amp_low, amp_high, amp_diff, reset_flag} = 6'b000000;
        chk_frame(SEL_AUX, 32'h00ffffff, st(1'b1, 1'b0), 1);
        check(status, st(1'b0, 1'b0));
    endtask

    task automatic t_sat;
        logic [33:0] praw [5] = '{34'h080000000, 34'h37fffffff, 34'h000000000, 34'h3ffffffff, 34'h012345678};
        logic [31:0] pexp [5] = '{PRI_POS_FS, PRI_NEG_FS, 32'h00000000, 32'hffffffff, 32'h12345678};
        logic [33:0] araw [3] = '{34'h0800000, 34'h37fffff, 34'h0000001};
        logic [31:0] aexp [3] = '{{8'h00, AUX_POS_FS}, {8'h00, AUX_NEG_FS}, 32'h00000001};
        wr_cfg(CFG_ADDR, 8'h01);
        for (int i = 0; i < 5; i++) begin
            store(1'b0, praw[i]);
            chk_frame(SEL_PRI, pexp[i], 8'h00, 1);
        end
        for (int i = 0; i < 3; i++) begin
            store(1'b1, araw[i]);
            chk_frame(SEL_AUX, aexp[i], 8'h00, 1);
        end
    endtask

    task automatic t_crc;
        wr_cfg(CFG_ADDR, 8'h06);
        store(1'b0, 34'h3a5c3e781);
        chk_frame(SEL_PRI, 32'ha5c3e781, st(1'b0, 1'b1), 1);
        store(1'b1, 34'h0000001);
        chk_frame(SEL_AUX, 32'h00000001, st(1'b1, 1'b0), 1);
        wr_cfg(8'h03, 8'h00);
        check(cfg, 8'h06);
        // Check mode 11 sends no check byte
        wr_cfg(CFG_ADDR, 8'h07);
        chk_frame(SEL_PRI, 32'ha5c3e781, st(1'b0, 1'b0), 1);
        chk_frame(SEL_REG, 32'h0000005a, 8'h00, 2);
    endtask

    // Unused read selection is dropped and leaves the new-data flag set
    task automatic t_refuse;
        store(1'b0, 34'h000000100);
        @(negedge clk_sys);
        cmd_sel = 2'h3;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        check(busy, 1'b0);
        @(negedge clk_sys);
        check(status, st(1'b0, 1'b1));
    endtask

    initial begin
        repeat (5) @(negedge clk_sys);
        check(busy, 1'b1);
        check(cfg, CFG_RST);
        rst_b = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(busy, 1'b0);
        check(status, 8'h00);
        t_status;
        t_sat;
        t_crc;
        t_refuse;
        end_sim;
    end
endmodule
